/* File: rtca_pkg.sv */
`default_nettype none
package rtca_pkg;
  // Register indices on the local register port; byte address = 4 * index
  localparam logic [7:0] IDX_CLOCK_CTRL = 8'h00;
  localparam logic [7:0] IDX_ALARM_CTRL = 8'h01;
  localparam logic [7:0] IDX_CUR_TIME   = 8'h02;
  localparam logic [7:0] IDX_CUR_DATE   = 8'h03;
  localparam logic [7:0] IDX_ALARM_TIME = 8'h04;
  localparam logic [7:0] IDX_ALARM_DATE = 8'h05;

  // Writable bits of the alarm value registers
  localparam logic [31:0] ALARM_TIME_MASK = 32'h3F7F_7F00;
  localparam logic [31:0] ALARM_DATE_MASK = 32'h001F_3F07;

  // Digit field masks, time register
  localparam logic [31:0] SEC_UNITS_M  = 32'h0000_0F00;
  localparam logic [31:0] SEC_TENS_M   = 32'h0000_7000;
  localparam logic [31:0] MIN_UNITS_M  = 32'h000F_0000;
  localparam logic [31:0] MIN_TENS_M   = 32'h0070_0000;
  localparam logic [31:0] HOUR_M       = 32'h3F00_0000;
  // Digit field masks, date register
  localparam logic [31:0] WDAY_M       = 32'h0000_0007;
  localparam logic [31:0] DAY_M        = 32'h0000_3F00;
  localparam logic [31:0] MONTH_M      = 32'h001F_0000;

  // Field positions
  localparam int SEC_LSB   = 8;
  localparam int MIN_LSB   = 16;
  localparam int HOUR_LSB  = 24;
  localparam int WDAY_LSB  = 0;
  localparam int DAY_LSB   = 8;
  localparam int MONTH_LSB = 16;
  localparam int YEAR_LSB  = 24;

  // Alarm control fields
  localparam int ALM_EN_BIT    = 15;
  localparam int ALM_CHIME_BIT = 14;
  localparam int ALM_PIV_BIT   = 13;
  localparam int ALM_MASK_LSB  = 8;
  localparam int ALM_RPT_LSB   = 0;
  // Clock control fields
  localparam int CLK_ON_BIT    = 15;
  localparam int CLK_SEL_LSB   = 9;
  localparam int CLK_HALF_BIT  = 1;

  // Clock source codes
  localparam logic [1:0] SRC_INTERNAL = 2'h0;
  localparam logic [1:0] SRC_EXTERNAL = 2'h1;

  // Alarm interval codes
  localparam logic [3:0] INT_HALF_SEC = 4'h0;
  localparam logic [3:0] INT_SECOND   = 4'h1;
  localparam logic [3:0] INT_TEN_SEC  = 4'h2;
  localparam logic [3:0] INT_MINUTE   = 4'h3;
  localparam logic [3:0] INT_TEN_MIN  = 4'h4;
  localparam logic [3:0] INT_HOUR     = 4'h5;
  localparam logic [3:0] INT_DAY      = 4'h6;
  localparam logic [3:0] INT_WEEK     = 4'h7;
  localparam logic [3:0] INT_MONTH    = 4'h8;
  localparam logic [3:0] INT_YEAR     = 4'h9;

  // Reset values; RPT_WRAP is the repeat count reload on chime wrap
  localparam logic [7:0]  RPT_RESET   = 8'h00;
  localparam logic [7:0]  RPT_WRAP    = 8'hFF;
  localparam logic [7:0]  DAY_RESET   = 8'h01;
  localparam logic [7:0]  MONTH_RESET = 8'h01;
  localparam logic [7:0]  ZERO_BCD    = 8'h00;

  // Counting clock: 32768 Hz nominal, half a second of its edges
  localparam int OSC_HZ             = 32768;
  localparam int TICKS_PER_HALF_SEC = OSC_HZ / 2;
endpackage : rtca_pkg
`default_nettype wire

/* File: rtca_bcd_pair.sv */
`default_nettype none
module rtca_bcd_pair #(
  parameter logic [7:0] RST_VAL = 8'h00
) (
  input  wire logic       clk_sys,
  input  wire logic       rst,
  input  wire logic       ce,
  input  wire logic       load,
  input  wire logic [7:0] load_val,
  input  wire logic       inc,
  input  wire logic [7:0] min_val,
  input  wire logic [7:0] max_val,
  output var  logic [7:0] value,
  output logic            carry
);
  logic [7:0] value_next;

  assign carry = inc && (value == max_val);

  // Units carry into tens at ten, not sixteen
  always_comb begin
    value_next = value;
    if (carry) begin
      value_next = min_val;
    end else if (value[3:0] >= 4'h9) begin
      value_next = {value[7:4] + 4'h1, 4'h0};
    end else begin
      value_next = {value[7:4], value[3:0] + 4'h1};
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      value <= RST_VAL;
    end else if (ce) begin
      if (load) begin
        value <= load_val;
      end else if (inc) begin
        value <= value_next;
      end
    end
  end
endmodule : rtca_bcd_pair
`default_nettype wire

/* File: rtca_alarm_match.sv */
`default_nettype none
module rtca_alarm_match
  import rtca_pkg::*;
(
  input  wire logic [31:0] cur_time,
  input  wire logic [31:0] cur_date,
  input  wire logic [31:0] alm_time,
  input  wire logic [31:0] alm_date,
  input  wire logic [3:0]  interval,
  input  wire logic        half_phase,
  output logic             match
);
  logic [31:0] tmask;
  logic [31:0] dmask;
  logic        legal;
  logic        whole_sec;

  // Longer intervals make more digit fields significant
  always_comb begin
    tmask = 32'h0000_0000;
    dmask = 32'h0000_0000;
    legal = 1'b1;
    unique case (interval)
      INT_HALF_SEC, INT_SECOND: begin
      end
      INT_TEN_SEC: tmask = SEC_UNITS_M;
      INT_MINUTE:  tmask = SEC_UNITS_M | SEC_TENS_M;
      INT_TEN_MIN: tmask = SEC_UNITS_M | SEC_TENS_M | MIN_UNITS_M;
      INT_HOUR:    tmask = SEC_UNITS_M | SEC_TENS_M | MIN_UNITS_M
                           | MIN_TENS_M;
      INT_DAY:     tmask = SEC_UNITS_M | SEC_TENS_M | MIN_UNITS_M
                           | MIN_TENS_M | HOUR_M;
      INT_WEEK: begin
        tmask = SEC_UNITS_M | SEC_TENS_M | MIN_UNITS_M | MIN_TENS_M
                | HOUR_M;
        dmask = WDAY_M;
      end
      INT_MONTH: begin
        tmask = SEC_UNITS_M | SEC_TENS_M | MIN_UNITS_M | MIN_TENS_M
                | HOUR_M;
        dmask = DAY_M;
      end
      INT_YEAR: begin
        tmask = SEC_UNITS_M | SEC_TENS_M | MIN_UNITS_M | MIN_TENS_M
                | HOUR_M;
        dmask = DAY_M | MONTH_M;
      end
      default: legal = 1'b0;
    endcase
  end

  // Only the half-second interval fires on the half-second phase
  assign whole_sec = (interval == INT_HALF_SEC) || !half_phase;
  assign match = legal && whole_sec
                 && (((cur_time ^ alm_time) & tmask) == 32'h0000_0000)
                 && (((cur_date ^ alm_date) & dmask) == 32'h0000_0000);
endmodule : rtca_alarm_match
`default_nettype wire

/* File: rtca_top.sv */
`default_nettype none
module rtca_top
  import rtca_pkg::*;
#(
  parameter int HALF_TICKS = TICKS_PER_HALF_SEC
) (
  input  wire logic        clk_sys,
  input  wire logic        rst,
  input  wire logic        ce,
  input  wire logic        tick_int_osc,
  input  wire logic        tick_ext_osc,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  input  wire logic [7:0]  reg_addr,
  input  wire logic [31:0] reg_wdata,
  output var  logic [31:0] reg_rdata,
  output var  logic        alarm_irq,
  output var  logic        alarm_pulse_out
);
  localparam logic [14:0] HALF_LAST = 15'(HALF_TICKS - 1);

  logic        wr_clk_ctrl;
  logic        wr_alm_ctrl;
  logic        wr_time;
  logic        wr_date;
  logic        wr_alm_time;
  logic        wr_alm_date;
  logic        addr_ok;
  logic [5:0]  reg_index;

  logic        on_reg;
  logic [1:0]  src_sel_reg;
  logic        src_tick;
  logic [14:0] presc_reg;
  logic        half_reg;
  logic        half_tick;
  logic        sec_tick;
  logic        eval_reg;

  logic [7:0]  sec_v;
  logic [7:0]  min_v;
  logic [7:0]  hour_v;
  logic [7:0]  day_v;
  logic [7:0]  month_v;
  logic [7:0]  year_v;
  logic [2:0]  wday_reg;
  logic        sec_c;
  logic        min_c;
  logic        hour_c;
  logic        day_c;
  logic        month_c;
  logic        leap;
  logic [7:0]  day_max;

  logic [31:0] cur_time;
  logic [31:0] cur_date;
  logic [31:0] alm_time_reg;
  logic [31:0] alm_date_reg;
  logic        alm_en_reg;
  logic        chime_reg;
  logic        piv_reg;
  logic [3:0]  interval_reg;
  logic [7:0]  rpt_reg;
  logic        match;
  logic        alarm_event;

  assign addr_ok   = (reg_addr[1:0] == 2'b00) && (reg_addr[7:6] == 2'b00);
  assign reg_index = reg_addr[7:2];
  assign wr_clk_ctrl = reg_wr && addr_ok && ({2'b00, reg_index}
                       == IDX_CLOCK_CTRL);
  assign wr_alm_ctrl = reg_wr && addr_ok && ({2'b00, reg_index}
                       == IDX_ALARM_CTRL);
  assign wr_time     = reg_wr && addr_ok && ({2'b00, reg_index}
                       == IDX_CUR_TIME);
  assign wr_date     = reg_wr && addr_ok && ({2'b00, reg_index}
                       == IDX_CUR_DATE);
  assign wr_alm_time = reg_wr && addr_ok && ({2'b00, reg_index}
                       == IDX_ALARM_TIME);
  assign wr_alm_date = reg_wr && addr_ok && ({2'b00, reg_index}
                       == IDX_ALARM_DATE);

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      on_reg      <= 1'b0;
      src_sel_reg <= SRC_INTERNAL;
    end else if (ce && wr_clk_ctrl) begin
      on_reg      <= reg_wdata[CLK_ON_BIT];
      src_sel_reg <= reg_wdata[CLK_SEL_LSB +: 2];
    end
  end

  // Reserved source codes give no counting edges at all
  always_comb begin
    unique case (src_sel_reg)
      SRC_INTERNAL: src_tick = tick_int_osc;
      SRC_EXTERNAL: src_tick = tick_ext_osc;
      default:      src_tick = 1'b0;
    endcase
  end

  // Prescaler; a seconds write restarts it for a known phase
  assign half_tick = on_reg && src_tick && (presc_reg == HALF_LAST);
  assign sec_tick  = half_tick && half_reg;

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      presc_reg <= 15'h0000;
      half_reg  <= 1'b0;
    end else if (ce) begin
      if (wr_time) begin
        presc_reg <= 15'h0000;
        half_reg  <= 1'b0;
      end else if (half_tick) begin
        presc_reg <= 15'h0000;
        half_reg  <= !half_reg;
      end else if (on_reg && src_tick) begin
        presc_reg <= presc_reg + 15'h0001;
      end
    end
  end

  // Leap year: BCD year divisible by four, 2000..2099 only
  assign leap = year_v[4] ? (year_v[3:0] == 4'h2 || year_v[3:0] == 4'h6)
                          : (year_v[3:0] == 4'h0 || year_v[3:0] == 4'h4
                             || year_v[3:0] == 4'h8);

  always_comb begin
    unique case (month_v)
      8'h02:                      day_max = leap ? 8'h29 : 8'h28;
      8'h04, 8'h06, 8'h09, 8'h11: day_max = 8'h30;
      default:                    day_max = 8'h31;
    endcase
  end

  rtca_bcd_pair #(.RST_VAL(ZERO_BCD)) u_sec (
    .clk_sys  (clk_sys),
    .rst      (rst),
    .ce       (ce),
    .load     (wr_time),
    .load_val ({1'b0, reg_wdata[SEC_LSB +: 7]}),
    .inc      (sec_tick),
    .min_val  (8'h00),
    .max_val  (8'h59),
    .value    (sec_v),
    .carry    (sec_c)
  );

  rtca_bcd_pair #(.RST_VAL(ZERO_BCD)) u_min (
    .clk_sys  (clk_sys),
    .rst      (rst),
    .ce       (ce),
    .load     (wr_time),
    .load_val ({1'b0, reg_wdata[MIN_LSB +: 7]}),
    .inc      (sec_c),
    .min_val  (8'h00),
    .max_val  (8'h59),
    .value    (min_v),
    .carry    (min_c)
  );

  rtca_bcd_pair #(.RST_VAL(ZERO_BCD)) u_hour (
    .clk_sys  (clk_sys),
    .rst      (rst),
    .ce       (ce),
    .load     (wr_time),
    .load_val ({2'b00, reg_wdata[HOUR_LSB +: 6]}),
    .inc      (min_c),
    .min_val  (8'h00),
    .max_val  (8'h23),
    .value    (hour_v),
    .carry    (hour_c)
  );

  rtca_bcd_pair #(.RST_VAL(DAY_RESET)) u_day (
    .clk_sys  (clk_sys),
    .rst      (rst),
    .ce       (ce),
    .load     (wr_date),
    .load_val ({2'b00, reg_wdata[DAY_LSB +: 6]}),
    .inc      (hour_c),
    .min_val  (8'h01),
    .max_val  (day_max),
    .value    (day_v),
    .carry    (day_c)
  );

  rtca_bcd_pair #(.RST_VAL(MONTH_RESET)) u_month (
    .clk_sys  (clk_sys),
    .rst      (rst),
    .ce       (ce),
    .load     (wr_date),
    .load_val ({3'b000, reg_wdata[MONTH_LSB +: 5]}),
    .inc      (day_c),
    .min_val  (8'h01),
    .max_val  (8'h12),
    .value    (month_v),
    .carry    (month_c)
  );

  // Year wraps 99 to 00 with nowhere to carry
  rtca_bcd_pair #(.RST_VAL(ZERO_BCD)) u_year (
    .clk_sys  (clk_sys),
    .rst      (rst),
    .ce       (ce),
    .load     (wr_date),
    .load_val (reg_wdata[YEAR_LSB +: 8]),
    .inc      (month_c),
    .min_val  (8'h00),
    .max_val  (8'h99),
    .value    (year_v),
    .carry    ()
  );

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      wday_reg <= 3'h0;
    end else if (ce) begin
      if (wr_date) begin
        wday_reg <= reg_wdata[WDAY_LSB +: 3];
      end else if (hour_c) begin
        wday_reg <= (wday_reg >= 3'h6) ? 3'h0 : wday_reg + 3'h1;
      end
    end
  end

  // One BCD digit per nibble, unused bits zero
  assign cur_time = {2'b00, hour_v[5:0], 1'b0, min_v[6:0], 1'b0,
                     sec_v[6:0], 8'h00};
  assign cur_date = {year_v, 3'b000, month_v[4:0], 2'b00, day_v[5:0],
                     5'b00000, wday_reg};

  // Only the digit fields store; the rest stays zero
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      alm_time_reg <= 32'h0000_0000;
      alm_date_reg <= 32'h0000_0000;
    end else if (ce) begin
      if (wr_alm_time) begin
        alm_time_reg <= reg_wdata & ALARM_TIME_MASK;
      end
      if (wr_alm_date) begin
        alm_date_reg <= reg_wdata & ALARM_DATE_MASK;
      end
    end
  end

  // Compare one cycle after the counters step, against the new time
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      eval_reg <= 1'b0;
    end else if (ce) begin
      eval_reg <= half_tick;
    end
  end

  rtca_alarm_match u_match (
    .cur_time   (cur_time),
    .cur_date   (cur_date),
    .alm_time   (alm_time_reg),
    .alm_date   (alm_date_reg),
    .interval   (interval_reg),
    .half_phase (half_reg),
    .match      (match)
  );

  assign alarm_event = ce && eval_reg && alm_en_reg && match;

  // A software write beats the same-cycle hardware update
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      alm_en_reg   <= 1'b0;
      chime_reg    <= 1'b0;
      interval_reg <= INT_HALF_SEC;
      rpt_reg      <= RPT_RESET;
    end else if (ce) begin
      if (wr_alm_ctrl) begin
        alm_en_reg   <= reg_wdata[ALM_EN_BIT];
        chime_reg    <= reg_wdata[ALM_CHIME_BIT];
        interval_reg <= reg_wdata[ALM_MASK_LSB +: 4];
        rpt_reg      <= reg_wdata[ALM_RPT_LSB +: 8];
      end else if (alarm_event) begin
        if (rpt_reg != RPT_RESET) begin
          rpt_reg <= rpt_reg - 8'h01;
        end else if (chime_reg) begin
          rpt_reg <= RPT_WRAP;
        end else begin
          alm_en_reg <= 1'b0;
        end
      end
    end
  end

  // Initial level is only taken while the alarm is off
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      piv_reg         <= 1'b0;
      alarm_pulse_out <= 1'b0;
    end else if (ce) begin
      if (wr_alm_ctrl && !alm_en_reg) begin
        piv_reg         <= reg_wdata[ALM_PIV_BIT];
        alarm_pulse_out <= reg_wdata[ALM_PIV_BIT];
      end else if (alarm_event) begin
        alarm_pulse_out <= !alarm_pulse_out;
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      alarm_irq <= 1'b0;
    end else if (ce) begin
      alarm_irq <= alarm_event;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      reg_rdata <= 32'h0000_0000;
    end else if (ce && reg_rd) begin
      reg_rdata <= 32'h0000_0000;
      if (addr_ok) begin
        unique case ({2'b00, reg_index})
          IDX_CLOCK_CTRL: begin
            reg_rdata[CLK_ON_BIT]       <= on_reg;
            reg_rdata[CLK_SEL_LSB +: 2] <= src_sel_reg;
            reg_rdata[CLK_HALF_BIT]     <= half_reg;
          end
          IDX_ALARM_CTRL: begin
            reg_rdata[ALM_EN_BIT]        <= alm_en_reg;
            reg_rdata[ALM_CHIME_BIT]     <= chime_reg;
            reg_rdata[ALM_PIV_BIT]       <= alm_en_reg ? alarm_pulse_out
                                                       : piv_reg;
            reg_rdata[ALM_MASK_LSB +: 4] <= interval_reg;
            reg_rdata[ALM_RPT_LSB +: 8]  <= rpt_reg;
          end
          IDX_CUR_TIME:   reg_rdata <= cur_time;
          IDX_CUR_DATE:   reg_rdata <= cur_date;
          IDX_ALARM_TIME: reg_rdata <= alm_time_reg;
          IDX_ALARM_DATE: reg_rdata <= alm_date_reg;
          default:        reg_rdata <= 32'h0000_0000;
        endcase
      end
    end
  end
endmodule : rtca_top
`default_nettype wire

/* File: rtca_chk.sv */
`default_nettype none
module rtca_chk
  import rtca_pkg::*;
#(
  parameter int HALF_TICKS = TICKS_PER_HALF_SEC
) (
  input wire logic        clk_sys,
  input wire logic        rst,
  input wire logic        ce,
  input wire logic        reg_wr,
  input wire logic        reg_rd,
  input wire logic [7:0]  reg_addr,
  input wire logic [31:0] reg_rdata,
  input wire logic        alarm_irq,
  input wire logic        alarm_pulse_out
);
  default clocking cb @(posedge clk_sys);
  endclocking
  // A frozen cycle holds every output, so nothing is judged while ce is low
  default disable iff (rst || !ce);

  logic ctl_acc;
  logic tim_rd;
  logic dat_rd;
  assign ctl_acc = reg_addr == {IDX_ALARM_CTRL[5:0], 2'b00};
  assign tim_rd  = reg_rd && reg_addr == {IDX_ALARM_TIME[5:0], 2'b00};
  assign dat_rd  = reg_rd && reg_addr == {IDX_ALARM_DATE[5:0], 2'b00};

  a_irq_spacing: assert property (alarm_irq |=> !alarm_irq [*3])
    else $error("alarm irq too long or events too close");
  a_irq_toggles: assert property (
    alarm_irq && $past(ce) |-> alarm_pulse_out != $past(alarm_pulse_out))
    else $error("alarm irq without pulse toggle");
  // A reload of the start level by a control write is the only other cause
  a_toggle_cause: assert property (
    !$past(rst) && alarm_pulse_out != $past(alarm_pulse_out)
    && !$past(reg_wr && ctl_acc) |-> alarm_irq)
    else $error("pulse toggled without alarm event");
  a_time_unused: assert property (
    tim_rd |=> (reg_rdata & ~32'h3F7F_7F00) == 32'h0000_0000)
    else $error("alarm time unused bits not zero");
  a_time_low_zero: assert property (
    tim_rd |=> reg_rdata[7:0] == 8'h00)
    else $error("alarm time low byte not zero");
  a_date_unused: assert property (
    dat_rd |=> (reg_rdata & ~32'h001F_3F07) == 32'h0000_0000)
    else $error("alarm date unused bits not zero");
  a_unmapped_zero: assert property (
    reg_rd && reg_addr[7:2] > 6'd5 |=> reg_rdata == 32'h0000_0000)
    else $error("unmapped read not zero");
  a_piv_reads_pulse: assert property (
    reg_rd && ctl_acc ##1 reg_rdata[ALM_EN_BIT]
    |-> reg_rdata[ALM_PIV_BIT] == $past(alarm_pulse_out))
    else $error("initial value bit does not show pulse level");
endmodule : rtca_chk

bind rtca_top rtca_chk #(
  .HALF_TICKS(HALF_TICKS)
) rtca_chk_i (
  .clk_sys        (clk_sys),
  .rst            (rst),
  .ce             (ce),
  .reg_wr         (reg_wr),
  .reg_rd         (reg_rd),
  .reg_addr       (reg_addr),
  .reg_rdata      (reg_rdata),
  .alarm_irq      (alarm_irq),
  .alarm_pulse_out(alarm_pulse_out)
);
`default_nettype wire

/* File: rtca_top_tb.sv */
`default_nettype none
module rtca_top_tb import rtca_pkg::*;;
  timeunit 1ns;
  timeprecision 1ns;

  logic        clk_sys;
  logic        rst;
  logic        ce;
  logic        tick_int_osc;
  logic        tick_ext_osc;
  logic        reg_wr;
  logic        reg_rd;
  logic [7:0]  reg_addr;
  logic [31:0] reg_wdata;
  logic [31:0] reg_rdata;
  logic        alarm_irq;
  logic        alarm_pulse_out;
  int          mismatches;
  int          cmp_count;
  int          irq_cnt;
  int          e;

  rtca_top #(.HALF_TICKS(4)) rtca_top_i (
    .clk_sys        (clk_sys),
    .rst            (rst),
    .ce             (ce),
    .tick_int_osc   (tick_int_osc),
    .tick_ext_osc   (tick_ext_osc),
    .reg_wr         (reg_wr),
    .reg_rd         (reg_rd),
    .reg_addr       (reg_addr),
    .reg_wdata      (reg_wdata),
    .reg_rdata      (reg_rdata),
    .alarm_irq      (alarm_irq),
    .alarm_pulse_out(alarm_pulse_out)
  );

  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end

  always @(posedge clk_sys) begin
    if (alarm_irq === 1'b1)
      irq_cnt <= irq_cnt + 1;
  end

  task automatic results();
    $display("Comparisons %0d, mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : results

  task automatic chk(input logic [31:0] exp, input logic [31:0] got);
    cmp_count++;
    if (got !== exp) begin
      mismatches++;
      $display("ERROR at %0t: expected %h, got %h", $time, exp, got);
    end
  endtask : chk

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    @(negedge clk_sys);
    reg_wr = 1'b0;
    @(negedge clk_sys);
  endtask : wr

  // Read data is valid one cycle after the strobe edge
  task automatic rd(input logic [7:0] a, input logic [31:0] m,
                    input logic [31:0] x);
    reg_addr = a;
    reg_rd = 1'b1;
    @(negedge clk_sys);
    reg_rd = 1'b0;
    chk(x, reg_rdata & m);
    @(negedge clk_sys);
  endtask : rd

  // src bit 0 pulses the crystal tick, bit 1 the internal one
  task automatic ticks(input int n, input logic [1:0] src);
    repeat (n) begin
      tick_ext_osc = src[0];
      tick_int_osc = src[1];
      @(negedge clk_sys);
      tick_ext_osc = 1'b0;
      tick_int_osc = 1'b0;
      @(negedge clk_sys);
    end
    repeat (4) @(negedge clk_sys);
  endtask : ticks

  task automatic roll(input logic [31:0] d, input logic [31:0] x);
    wr(8'h08, 32'h2359_5900);
    wr(8'h0C, d);
    ticks(8, 2'b01);
    rd(8'h08, 32'hFFFF_FFFF, 32'h0000_0000);
    rd(8'h0C, 32'hFFFF_FFFF, x);
  endtask : roll

  initial begin
    repeat (20000) @(posedge clk_sys);
    mismatches++;
    results();
  end

  initial begin
    {rst, ce} = 2'b11;
    {tick_int_osc, tick_ext_osc, reg_wr, reg_rd} = 4'h0;
    reg_addr = 8'h00;
    reg_wdata = 32'h0000_0000;
    {mismatches, cmp_count, irq_cnt} = '0;
    repeat (12) @(negedge clk_sys);
    rst = 1'b0;
    rd(8'h10, 32'hFFFF_FFFF, 32'h0000_0000);
    rd(8'h14, 32'hFFFF_FFFF, 32'h0000_0000);
    wr(8'h10, 32'hFFFF_FFFF);
    rd(8'h10, 32'hFFFF_FFFF, 32'h3F7F_7F00);
    wr(8'h10, 32'h2359_5900);
    rd(8'h10, 32'hFFFF_FFFF, 32'h2359_5900);
    wr(8'h14, 32'hFFFF_FFFF);
    rd(8'h14, 32'hFFFF_FFFF, 32'h001F_3F07);
    wr(8'h14, 32'h0012_3106);
    rd(8'h14, 32'hFFFF_FFFF, 32'h0012_3106);
    rd(8'h18, 32'hFFFF_FFFF, 32'h0000_0000);
    rd(8'h11, 32'hFFFF_FFFF, 32'h0000_0000);
    wr(8'h00, 32'h0000_0002);
    rd(8'h00, 32'h0000_0002, 32'h0000_0000);
    wr(8'h08, 32'h0000_0000);
    wr(8'h00, 32'h0000_8200);
    ticks(4, 2'b01);
    rd(8'h00, 32'h0000_0002, 32'h0000_0002);
    ticks(4, 2'b01);
    rd(8'h08, 32'hFFFF_FFFF, 32'h0000_0100);
    ticks(8, 2'b10);
    rd(8'h08, 32'hFFFF_FFFF, 32'h0000_0100);
    wr(8'h00, 32'h0000_8000);
    ticks(8, 2'b10);
    rd(8'h08, 32'hFFFF_FFFF, 32'h0000_0200);
    wr(8'h00, 32'h0000_8400);
    ticks(8, 2'b11);
    rd(8'h08, 32'hFFFF_FFFF, 32'h0000_0200);
    wr(8'h00, 32'h0000_8200);
    // Clock enable low freezes counters and ignores writes
    ce = 1'b0;
    ticks(8, 2'b01);
    wr(8'h10, 32'h0000_0000);
    ce = 1'b1;
    rd(8'h08, 32'hFFFF_FFFF, 32'h0000_0200);
    rd(8'h10, 32'hFFFF_FFFF, 32'h2359_5900);
    roll(32'h0402_2800, 32'h0402_2901);
    roll(32'h0102_2803, 32'h0103_0104);
    roll(32'h9912_3106, 32'h0001_0100);
    wr(8'h04, 32'h0000_2000);
    chk(32'h1, {31'h0, alarm_pulse_out});
    wr(8'h04, 32'h0000_A002);
    wr(8'h04, 32'h0000_8002);
    rd(8'h04, 32'h0000_2000, 32'h0000_2000);
    wr(8'h08, 32'h0000_0000);
    ticks(4, 2'b01);
    rd(8'h04, 32'hFFFF_DFFF, 32'h0000_8001);
    chk(32'h0, {31'h0, alarm_pulse_out});
    ticks(12, 2'b01);
    rd(8'h04, 32'hFFFF_DFFF, 32'h0000_0000);
    chk(32'd3, 32'(irq_cnt));
    chk(32'h0, {31'h0, alarm_pulse_out});
    wr(8'h04, 32'h0000_C000);
    ticks(4, 2'b01);
    rd(8'h04, 32'hFFFF_DFFF, 32'h0000_C0FF);
    wr(8'h04, 32'h0000_0000);
    // Alarm date equals the current date, so only seconds decide
    wr(8'h14, 32'h0001_0100);
    for (int s = 1; s <= 2; s++) begin
      for (int m = 0; m <= 10; m++) begin
        e = (m == 0) ? 2 : (m == 1) ? 1 : (m <= 9 && s == 1) ? 1 : 0;
        wr(8'h10, 32'(s) << 8);
        wr(8'h08, 32'h0000_0000);
        irq_cnt = 0;
        wr(8'h04, 32'h0000_C000 | (32'(m) << 8));
        ticks(8, 2'b01);
        wr(8'h04, 32'h0000_0000);
        chk(32'(e), 32'(irq_cnt));
      end
    end
    results();
  end
endmodule : rtca_top_tb
`default_nettype wire
